// file: pamux_top.sv
// Port A pin multiplexer with APB register slave and alternate-function overrides
//
// How it works
// - A one in a port's break-before-make bit enables it for that port.
// - Under break-before-make, a new output first stays tri-stated one cycle.
// - Port pull-up-off bit kills pull-ups even for input pins with value one.
// - Effective pull-up disable is port bit OR global bit.
// - Pin 7 outputs the reference only when enabled and internal reference used.
// - Reference output on pin 7 turns off its pull-up and driver.
// - External reference or bypass use also keeps pin 7 pull-up and driver off.
// - SPI slave forces pin 6 to input.
// - SPI slave is selected only while pin 6 is held low.
// - SPI master leaves pin 6 direction to its drive select bit.
// - Forced-input pin 6 pull-up still follows its output value bit.
// - Pin 5 is input in SPI slave; master uses direction bit; pull-up kept.
// - Pin 4 is input in SPI slave; master uses direction bit; pull-up kept.
// - Three-wire data input on pin 4 never overrides normal port control.
// - Three-wire data output drives pin 2 only while its direction bit is one.
// - Three-wire output selected, pin 2 as input: value bit still enables pull-up.
// - Timer compare output appears on pin 2 only when its direction bit is one.
// - SPI master forces pin 2 to input; slave uses its direction bit.
// - Forced-input pin 2 pull-up follows its output value bit.
// - Default pull-up is on for input, value one, no effective disable.
// - Drive override enable makes driver follow the override value.
// - Value override enable with driver on drives the override value.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pamux_top
   import pamux_pkg::*;
(
   input  wire logic        pclk,             // APB clock, 50 MHz
   input  wire logic        presetn,          // Async reset, active low
   input  wire logic        psel,             // APB select
   input  wire logic        penable,          // APB enable
   input  wire logic        pwrite,           // APB direction
   input  wire logic [9:0]  paddr,            // APB byte address
   input  wire logic [31:0] pwdata,           // APB write data
   output logic [31:0]      prdata,           // APB read data
   output logic             pready,           // APB ready
   output logic             pslverr,          // APB error on unmapped
   input  wire logic [7:0]  pad_in,           // Pad input levels
   output logic [7:0]       pad_out,          // Pad output values
   output logic [7:0]       pad_oe_n,         // Pad driver enable, low drives
   output logic [7:0]       pad_pullup,       // Pad pull-up enable
   output logic             port_b_bbm,       // Port B break-before-make
   output logic             port_b_pullup_off,// Port B effective pull-up off
   input  wire logic        spi_enable,       // SPI enabled
   input  wire logic        spi_master,       // SPI master mode
   input  wire logic        spi_sck_out,      // SPI master clock out
   input  wire logic        spi_mosi_out,     // SPI master data out
   input  wire logic        spi_miso_out,     // SPI slave data out
   output logic             spi_slave_sel,    // SPI slave selected
   input  wire logic        usi_three_wire_sel,// Three-wire data output on
   input  wire logic        usi_shiftout,     // Three-wire data out bit
   output logic             usi_three_wire_data_in, // Three-wire data input
   output logic             usi_data_in_valid,// Pin 4 usable as input
   input  wire logic        timer0_compare_sel,// Compare output enabled
   input  wire logic        timer0_compare_out,// Compare waveform
   input  wire logic        ref_output_enable,// Reference output enable
   input  wire logic        adc_ref_internal, // Converter uses 2.56V or 1.1V
   input  wire logic        adc_ref_external, // External ref or bypass cap
   output logic             internal_ref_output // Reference drive on pin 7
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [7:0] drive_a;     // pin_drive_select, port A
   logic [7:0] value_a;     // output_value_bit, port A
   logic [7:0] port_ctrl;   // port_control_reg
   logic [7:0] mcu_ctrl;    // mcu_control_reg
   logic [7:0] bbm_hold;    // One-cycle tri-state gap per pin
   logic       ack;         // APB wait-state flop

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire logic       access;
   wire logic       wr_en;
   wire logic       hit_pin;
   wire logic       hit_drive;
   wire logic       hit_value;
   wire logic       hit_pctl;
   wire logic       hit_mctl;
   wire logic       addr_hit;
   wire logic [7:0] rd_mux;

   // One wait state so read data can come from a flop
   assign access    = psel & penable;
   assign pready    = ack;
   assign wr_en     = access & pwrite & ack;
   assign hit_pin   = (paddr == pamux_addr(PAMUX_IDX_PIN_IN));
   assign hit_drive = (paddr == pamux_addr(PAMUX_IDX_DRIVE));
   assign hit_value = (paddr == pamux_addr(PAMUX_IDX_VALUE));
   assign hit_pctl  = (paddr == pamux_addr(PAMUX_IDX_PORT_CTRL));
   assign hit_mctl  = (paddr == pamux_addr(PAMUX_IDX_MCU_CTRL));
   assign addr_hit  = hit_pin | hit_drive | hit_value | hit_pctl | hit_mctl;
   assign pslverr   = ack & ~addr_hit;

   // Read selection; reserved bits are masked out of the stored copy
   assign rd_mux = hit_pin   ? pad_in    :
                   hit_drive ? drive_a   :
                   hit_value ? value_a   :
                   hit_pctl  ? port_ctrl :
                   hit_mctl  ? mcu_ctrl  : 8'h00;

   // Wait-state flop: ready follows the first access cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ack <= 1'b0;
      else
         ack <= access & ~ack;
   end

   // Read data captured in the wait cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (access & ~ack & ~pwrite)
         prdata <= {24'h00_0000, rd_mux};
   end

   // ----------------------------------------------------------------
   // Software registers
   // ----------------------------------------------------------------
   wire logic [7:0] next_drive_a;
   wire logic       bbm_a;
   wire logic       pulloff_eff_a;

   assign next_drive_a = pwdata[7:0];
   assign bbm_a        = port_ctrl[PAMUX_BIT_BBM_A];
   // Port bit and global bit both disable pull-ups
   assign pulloff_eff_a = port_ctrl[PAMUX_BIT_PULLOFF_A]
                        | mcu_ctrl[PAMUX_BIT_GPUD];
   assign port_b_bbm        = port_ctrl[PAMUX_BIT_BBM_B];
   assign port_b_pullup_off = port_ctrl[PAMUX_BIT_PULLOFF_B]
                            | mcu_ctrl[PAMUX_BIT_GPUD];

   // Register writes take effect on the ready edge only
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         drive_a   <= PAMUX_DRIVE_RESET;
         value_a   <= PAMUX_VALUE_RESET;
         port_ctrl <= PAMUX_PORT_CTRL_RESET;
         mcu_ctrl  <= PAMUX_MCU_CTRL_RESET;
      end
      else if (wr_en)
      begin
         if (hit_drive)
            drive_a <= next_drive_a;
         if (hit_value)
            value_a <= pwdata[7:0];
         if (hit_pctl)
            port_ctrl <= pwdata[7:0] & PAMUX_PORT_CTRL_MASK;
         if (hit_mctl)
            mcu_ctrl <= pwdata[7:0] & PAMUX_MCU_CTRL_MASK;
      end
   end

   // Gap flop: set only for pins newly turned to output under the mode
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         bbm_hold <= 8'h00;
      else if (wr_en & hit_drive & bbm_a)
         bbm_hold <= next_drive_a & ~drive_a;
      else
         bbm_hold <= 8'h00;
   end

   // ----------------------------------------------------------------
   // Alternate-function override generation
   // ----------------------------------------------------------------
   wire logic spi_slave;
   wire logic spi_mst;
   wire logic ref_active;
   wire logic ref_pin_off;
   wire logic usi_do;
   wire logic timer_do;
   pamux_ovr_t ovr [8];

   assign spi_slave   = spi_enable & ~spi_master;
   assign spi_mst     = spi_enable & spi_master;
   // Internal reference reaches the pin only with a matching source
   assign ref_active  = ref_output_enable & adc_ref_internal;
   assign ref_pin_off = ref_active | adc_ref_external;
   // SPI owns pin 2 first, then three-wire output, then the timer
   assign usi_do      = ~spi_enable & usi_three_wire_sel;
   assign timer_do    = ~spi_enable & ~usi_three_wire_sel & timer0_compare_sel;

   // Pins 0, 1 and 3 carry no digital overrides here
   assign ovr[0] = '0;
   assign ovr[1] = '0;
   assign ovr[3] = '0;

   // Pin 2: master input forced, slave/three-wire/timer drive value
   assign ovr[PAMUX_PIN_MISO] = '{
      pull_ovr_en:  spi_mst,
      pull_ovr_val: value_a[PAMUX_PIN_MISO] & ~pulloff_eff_a,
      dir_ovr_en:   spi_mst,
      dir_ovr_val:  1'b0,
      val_ovr_en:   spi_slave | usi_do | timer_do,
      val_ovr_val:  spi_slave ? spi_miso_out :
                    usi_do    ? usi_shiftout : timer0_compare_out
   };

   // Pin 4: three-wire input leaves it alone; SPI slave forces input
   assign ovr[PAMUX_PIN_MOSI] = '{
      pull_ovr_en:  spi_slave,
      pull_ovr_val: value_a[PAMUX_PIN_MOSI] & ~pulloff_eff_a,
      dir_ovr_en:   spi_slave,
      dir_ovr_val:  1'b0,
      val_ovr_en:   spi_mst,
      val_ovr_val:  spi_mosi_out
   };

   // Pin 5: clock in as slave, clock out as master
   assign ovr[PAMUX_PIN_SCK] = '{
      pull_ovr_en:  spi_slave,
      pull_ovr_val: value_a[PAMUX_PIN_SCK] & ~pulloff_eff_a,
      dir_ovr_en:   spi_slave,
      dir_ovr_val:  1'b0,
      val_ovr_en:   spi_mst,
      val_ovr_val:  spi_sck_out
   };

   // Pin 6: select input; master keeps the register direction
   assign ovr[PAMUX_PIN_SS] = '{
      pull_ovr_en:  spi_slave,
      pull_ovr_val: value_a[PAMUX_PIN_SS] & ~pulloff_eff_a,
      dir_ovr_en:   spi_slave,
      dir_ovr_val:  1'b0,
      val_ovr_en:   1'b0,
      val_ovr_val:  1'b0
   };

   // Pin 7: reference output or external reference turns off pull-up and digital driver
   assign ovr[PAMUX_PIN_REF] = '{
      pull_ovr_en:  ref_pin_off,
      pull_ovr_val: 1'b0,
      dir_ovr_en:   ref_pin_off,
      dir_ovr_val:  1'b0,
      val_ovr_en:   1'b0,
      val_ovr_val:  1'b0
   };

   // ----------------------------------------------------------------
   // Pin cells
   // ----------------------------------------------------------------
   logic [7:0] drive_en;
   logic [7:0] drive_val;
   logic [7:0] pull_en;

   // Port pull-up disable applies through each cell
   for (genvar i = 0; i < 8; i++)
   begin : g_pin
      pamux_pin_cell u_cell (
         .dir       (drive_a[i]),
         .val       (value_a[i]),
         .pulloff_eff (pulloff_eff_a),
         .bbm_hold  (bbm_hold[i]),
         .ovr       (ovr[i]),
         .drive_en  (drive_en[i]),
         .drive_val (drive_val[i]),
         .pull_en   (pull_en[i])
      );
   end

   // ----------------------------------------------------------------
   // Pad registers
   // ----------------------------------------------------------------
   // Registered pads avoid glitches when several overrides switch together
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pad_out             <= 8'h00;
         pad_oe_n            <= 8'hFF;
         pad_pullup          <= 8'h00;
         internal_ref_output <= 1'b0;
      end
      else
      begin
         pad_out             <= drive_val & drive_en;
         pad_oe_n            <= ~drive_en;
         pad_pullup          <= pull_en;
         internal_ref_output <= ref_active;
      end
   end

   // ----------------------------------------------------------------
   // Peripheral-side inputs
   // ----------------------------------------------------------------
   // Slave select is live only while the far end pulls pin 6 low
   assign spi_slave_sel = spi_slave & ~pad_in[PAMUX_PIN_SS];
   // Three-wire input only meaningful when software left pin 4 an input
   assign usi_three_wire_data_in = pad_in[PAMUX_PIN_MOSI];
   assign usi_data_in_valid      = ~drive_en[PAMUX_PIN_MOSI];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_bbm_gap;
      ($rose(drive_a[0]) && bbm_a) ##1 drive_a[0] |-> pad_oe_n[0] ##1 !pad_oe_n[0];
   endproperty
   a_bbm_gap: assert property (p_bbm_gap) else $error("no break-before-make gap");

   property p_no_bbm;
      $rose(drive_a[0]) && !bbm_a |=> !pad_oe_n[0];
   endproperty
   a_no_bbm: assert property (p_no_bbm) else $error("driver late without gap");

   property p_pud;
      pulloff_eff_a |=> !pad_pullup[0] && !pad_pullup[3];
   endproperty
   a_pud: assert property (p_pud) else $error("pull-up on while disabled");

   property p_ss_input;
      spi_slave |=> pad_oe_n[PAMUX_PIN_SS] && pad_oe_n[PAMUX_PIN_SCK];
   endproperty
   a_ss_input: assert property (p_ss_input) else $error("slave pins driven");

   property p_miso_input;
      spi_mst |=> pad_oe_n[PAMUX_PIN_MISO];
   endproperty
   a_miso_input: assert property (p_miso_input) else $error("master input driven");

   property p_ref_off;
      ref_active |=> internal_ref_output && pad_oe_n[7] && !pad_pullup[7];
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference pin not released");

   property p_sck_drive;
      spi_mst && drive_a[PAMUX_PIN_SCK] && !bbm_hold[PAMUX_PIN_SCK]
         |=> !pad_oe_n[PAMUX_PIN_SCK] && pad_out[PAMUX_PIN_SCK] == $past(spi_sck_out);
   endproperty
   a_sck_drive: assert property (p_sck_drive) else $error("master clock not driven");

   property p_timer;
      timer_do && drive_a[2] && !bbm_hold[2] |=> pad_out[2] == $past(timer0_compare_out);
   endproperty
   a_timer: assert property (p_timer) else $error("compare output missing");

   property p_reserved;
      pready && !pwrite && hit_pctl |-> prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");

   property p_ss_sel;
      spi_mst |-> !spi_slave_sel;
   endproperty
   a_ss_sel: assert property (p_ss_sel) else $error("master reports slave select");

   c_bbm: cover property ($rose(drive_a[0]) && bbm_a ##1 pad_oe_n[0] ##1 !pad_oe_n[0]);
   c_slave_sel: cover property (spi_slave_sel);
   c_ref: cover property ($rose(internal_ref_output));
   c_write: cover property (wr_en && hit_pctl);

endmodule : pamux_top
`default_nettype wire

// file: pamux_pkg.sv
// Constants, register map and carrier types for the port A pin multiplexer
package pamux_pkg;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [7:0] PAMUX_IDX_PIN_IN    = 8'h00;  // Pad levels, read only
   localparam logic [7:0] PAMUX_IDX_DRIVE     = 8'h01;  // pin_drive_select, port A
   localparam logic [7:0] PAMUX_IDX_VALUE     = 8'h02;  // output_value_bit, port A
   localparam logic [7:0] PAMUX_IDX_PORT_CTRL = 8'h12;  // port_control_reg
   localparam logic [7:0] PAMUX_IDX_MCU_CTRL  = 8'h35;  // mcu_control_reg

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int PAMUX_BIT_PULLOFF_A = 0;  // port_pullup_off, port A
   localparam int PAMUX_BIT_PULLOFF_B = 1;  // port_pullup_off, port B
   localparam int PAMUX_BIT_BBM_A     = 4;  // break_before_make_enable, port A
   localparam int PAMUX_BIT_BBM_B     = 5;  // break_before_make_enable, port B
   localparam int PAMUX_BIT_GPUD      = 4;  // global_pullup_off in mcu_control_reg

   // Pins carrying alternate functions
   localparam int PAMUX_PIN_MISO = 2;
   localparam int PAMUX_PIN_MOSI = 4;
   localparam int PAMUX_PIN_SCK  = 5;
   localparam int PAMUX_PIN_SS   = 6;
   localparam int PAMUX_PIN_REF  = 7;

   // ----------------------------------------------------------------
   // Writable masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] PAMUX_PORT_CTRL_MASK  = 8'h33;
   localparam logic [7:0] PAMUX_MCU_CTRL_MASK   = 8'h10;
   localparam logic [7:0] PAMUX_PORT_CTRL_RESET = 8'h00;
   localparam logic [7:0] PAMUX_MCU_CTRL_RESET  = 8'h00;
   localparam logic [7:0] PAMUX_DRIVE_RESET     = 8'h00;
   localparam logic [7:0] PAMUX_VALUE_RESET     = 8'h00;

   // Override bundle driven by a peripheral for one pin
   typedef struct packed {
      logic pull_ovr_en;   // pullup_override_en
      logic pull_ovr_val;  // pullup_override_val
      logic dir_ovr_en;    // drive_override_en
      logic dir_ovr_val;   // drive_override_val
      logic val_ovr_en;    // value_override_en
      logic val_ovr_val;   // value_override_val
   } pamux_ovr_t;

   // Byte address of a register index
   function automatic logic [9:0] pamux_addr(input logic [7:0] idx);
      pamux_addr = {idx, 2'b00};
   endfunction : pamux_addr

endpackage : pamux_pkg

// file: pamux_pin_cell.sv
// Per-pin override resolution: pull-up, driver enable and driven value
`timescale 1ns/100ps
`default_nettype none
module pamux_pin_cell
   import pamux_pkg::*;
(
   input  wire logic              dir,       // pin_drive_select bit
   input  wire logic              val,       // output_value_bit
   input  wire logic              pulloff_eff, // Effective pull-up disable
   input  wire logic              bbm_hold,  // Break-before-make gap
   input  wire pamux_pkg::pamux_ovr_t ovr,   // Peripheral overrides
   output logic                   drive_en,  // Output driver enable
   output logic                   drive_val, // Value to drive
   output logic                   pull_en    // Pull-up enable
);

   // ----------------------------------------------------------------
   // Override resolution
   // ----------------------------------------------------------------
   wire logic base_pullup;
   wire logic dir_sel;

   // Plain pull-up needs input, value one, no disable
   assign base_pullup = ~dir & val & ~pulloff_eff;
   assign pull_en     = ovr.pull_ovr_en ? ovr.pull_ovr_val : base_pullup;
   // Peripheral direction wins over the register bit
   assign dir_sel     = ovr.dir_ovr_en ? ovr.dir_ovr_val : dir;
   // Gap cycle keeps the driver off while switching to output
   assign drive_en    = dir_sel & ~bbm_hold;
   assign drive_val   = ovr.val_ovr_en ? ovr.val_ovr_val : val;

endmodule : pamux_pin_cell
`default_nettype wire

// file: pamux_periph_model.sv
// Behavioural model of the peripherals that drive the pin override inputs
`timescale 1ns/100ps
`default_nettype none
module pamux_periph_model
(
   input  wire logic [2:0]  mode, // 0 idle 1 slave 2 master 3 usi 4 timer 5 internal_ref_output 6 ext 7 ref off
   output logic      [11:0] pv    // Override inputs, SPI enable down to external reference
);
   // Data lines sit at one, so an override stands out against a zero value bit
   assign pv = {mode == 3'h1 || mode == 3'h2, mode == 3'h2, 3'b111, mode == 3'h3, 1'b1,
                mode == 3'h4, 1'b1, mode == 3'h5 || mode == 3'h7, mode == 3'h5, mode == 3'h6};
endmodule : pamux_periph_model
`default_nettype wire

// file: pamux_top_bench.sv
// Self-checking bench for the port A pin multiplexer
`timescale 1ns/100ps
`default_nettype none
module pamux_top_bench;
   import pamux_pkg::*;
   typedef struct packed {
      logic [2:0]  md;   // Peripheral mode
      logic [31:0] regs; // Drive, value, port control, mcu control
      logic [24:0] ex;   // Oe_n, out, pull-up, reference drive
   } pamux_row_t;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic        pready, pslverr, port_b_bbm, port_b_pullup_off, spi_slave_sel;
   logic        usi_three_wire_data_in, usi_data_in_valid, internal_ref_output;
   logic [7:0]  pad_in = 8'h00, pad_out, pad_oe_n, pad_pullup;
   logic [2:0]  mode = 3'h0;
   logic [11:0] pv;
   int          n_errors = 0, n_tests = 0, cyc = 0;
   // Pad expectations per override mode; data lines of the model are all one
   pamux_row_t rows [16] = '{
      {3'h0, 32'h0FF50000, 8'hF0, 8'h05, 8'hF0, 1'b0},
      {3'h0, 32'h0FF50100, 8'hF0, 8'h05, 8'h00, 1'b0},
      {3'h0, 32'h0FF50010, 8'hF0, 8'h05, 8'h00, 1'b0},
      {3'h0, 32'h0FF50200, 8'hF0, 8'h05, 8'hF0, 1'b0},
      {3'h1, 32'hFF000000, 8'h70, 8'h04, 8'h00, 1'b0},
      {3'h1, 32'h00FF0000, 8'hFF, 8'h00, 8'hFF, 1'b0},
      {3'h2, 32'hFF000000, 8'h04, 8'h30, 8'h00, 1'b0},
      {3'h2, 32'h00FF0000, 8'hFF, 8'h00, 8'hFF, 1'b0},
      {3'h2, 32'h00FF0100, 8'hFF, 8'h00, 8'h00, 1'b0},
      {3'h3, 32'h04000000, 8'hFB, 8'h04, 8'h00, 1'b0},
      {3'h3, 32'h00040000, 8'hFF, 8'h00, 8'h04, 1'b0},
      {3'h4, 32'h04000000, 8'hFB, 8'h04, 8'h00, 1'b0},
      {3'h4, 32'h00000000, 8'hFF, 8'h00, 8'h00, 1'b0},
      {3'h5, 32'h80800000, 8'hFF, 8'h00, 8'h00, 1'b1},
      {3'h6, 32'h80800000, 8'hFF, 8'h00, 8'h00, 1'b0},
      {3'h7, 32'h00800000, 8'hFF, 8'h00, 8'h80, 1'b0}};

   always #10 pclk = ~pclk;

   pamux_periph_model i_periph (.mode(mode), .pv(pv));
   pamux_top i_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pad_pullup(pad_pullup),
      .port_b_bbm(port_b_bbm), .port_b_pullup_off(port_b_pullup_off),
      .spi_enable(pv[11]), .spi_master(pv[10]), .spi_sck_out(pv[9]), .spi_mosi_out(pv[8]),
      .spi_miso_out(pv[7]), .spi_slave_sel(spi_slave_sel), .usi_three_wire_sel(pv[6]),
      .usi_shiftout(pv[5]), .usi_three_wire_data_in(usi_three_wire_data_in),
      .usi_data_in_valid(usi_data_in_valid), .timer0_compare_sel(pv[4]),
      .timer0_compare_out(pv[3]), .ref_output_enable(pv[2]), .adc_ref_internal(pv[1]),
      .adc_ref_external(pv[0]), .internal_ref_output(internal_ref_output));

   // --------------------------------------------------------------
   // Check, bus and report tasks
   // --------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; on a read d is the expected byte, er the expected error
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                      input logic er);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {idx, 2'b00};
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      if (!wr) chk(prdata, {24'h000000, d});
      chk({31'h0, pslverr}, {31'h0, er});
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic results;
      $display("tests %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : results

   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         results();
      end
   end

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(negedge pclk);
      chk({8'h00, pad_oe_n, pad_out, pad_pullup}, 32'h00FF0000);
      apb(0, PAMUX_IDX_PORT_CTRL, 8'h00, 0);
      apb(1, PAMUX_IDX_PORT_CTRL, 8'hFF, 0);
      apb(0, PAMUX_IDX_PORT_CTRL, 8'h33, 0);
      chk({30'h0, port_b_bbm, port_b_pullup_off}, 32'h3);
      apb(1, PAMUX_IDX_PORT_CTRL, 8'h00, 0);
      apb(1, PAMUX_IDX_MCU_CTRL, 8'hFF, 0);
      apb(0, PAMUX_IDX_MCU_CTRL, 8'h10, 0);
      chk({30'h0, port_b_bbm, port_b_pullup_off}, 32'h1);
      apb(0, 8'h3F, 8'h00, 1);
      apb(1, PAMUX_IDX_MCU_CTRL, 8'h00, 0);
      $display("test registers done");
      // Port A gap versus port B bit only: pin 0 turned to output
      for (int b = 0; b < 2; b++)
      begin
         apb(1, PAMUX_IDX_DRIVE, 8'h00, 0);
         apb(1, PAMUX_IDX_PORT_CTRL, b ? 8'h20 : 8'h10, 0);
         apb(1, PAMUX_IDX_DRIVE, 8'h01, 0);
         @(posedge pclk);
         @(negedge pclk);
         chk({31'h0, pad_oe_n[0]}, {31'h0, b == 0});
         @(negedge pclk);
         chk({31'h0, pad_oe_n[0]}, 32'h0);
      end
      $display("test break before make done");
      foreach (rows[i])
      begin
         @(posedge pclk);
         mode <= rows[i].md;
         apb(1, PAMUX_IDX_DRIVE, rows[i].regs[31:24], 0);
         apb(1, PAMUX_IDX_VALUE, rows[i].regs[23:16], 0);
         apb(1, PAMUX_IDX_PORT_CTRL, rows[i].regs[15:8], 0);
         apb(1, PAMUX_IDX_MCU_CTRL, rows[i].regs[7:0], 0);
         repeat (2) @(posedge pclk);
         @(negedge pclk);
         chk({7'h0, pad_oe_n, pad_out, pad_pullup, internal_ref_output},
             {7'h0, rows[i].ex});
      end
      $display("test override table done");
      // Slave select low then high, then three-wire data input on pin 4
      @(posedge pclk);
      mode <= 3'h1;
      @(negedge pclk);
      chk({31'h0, spi_slave_sel}, 32'h1);
      @(posedge pclk);
      pad_in <= 8'h50;
      @(negedge pclk);
      chk({31'h0, spi_slave_sel}, 32'h0);
      @(posedge pclk);
      mode <= 3'h0;
      @(negedge pclk);
      chk({30'h0, usi_data_in_valid, usi_three_wire_data_in}, 32'h3);
      apb(1, PAMUX_IDX_DRIVE, 8'h10, 0);
      @(posedge pclk);
      @(negedge pclk);
      chk({31'h0, usi_data_in_valid}, 32'h0);
      $display("test select and data input done");
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      chk({8'h00, pad_oe_n, pad_out, pad_pullup}, 32'h00FF0000);
      @(posedge pclk);
      presetn <= 1'b1;
      apb(0, PAMUX_IDX_DRIVE, 8'h00, 0);
      $display("test mid-run reset done");
      results();
   end
endmodule : pamux_top_bench
`default_nettype wire
